// ===== hw/edoc_ctrl.sv
// controller for a 64K x 16 page-mode dram: one access per request, refresh by column-first cycles
// assumes the dram sits on the pins with no glue; requests held until ack
//
// How it works
// - late write and rmw keep output gate high through the write portion
// - data presented before column strobe in early write, no later than write strobe in late write
// - page accesses hold strobe high and low at least a minimum cycle each
// - refresh setup from first byte strobe falling, hold to last rising
// - each byte strobe meets minimum pulse width on its own
// - all 256 rows refreshed within every 4 ms
`timescale 1ns/100ps
module edoc_ctrl #(
  parameter int REFRESH_INTERVAL = edoc_pkg::REFRESH_INTERVAL_CYC,
  parameter int PULSE = edoc_pkg::MIN_PULSE_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic req,
  input wire logic [1:0] req_cmd,
  input wire logic [15:0] req_addr,
  input wire logic [1:0] req_be,
  input wire logic [15:0] req_wdata,
  output logic ack,
  output logic [15:0] rdata,
  output logic busy,
  output edoc_pkg::edoc_strobes_s strobes,
  output logic [7:0] addr_out,
  output logic [15:0] dq_out,
  output logic dq_oe,
  input wire logic [15:0] dq_in
);
  typedef enum {ST_IDLE, ST_ROW, ST_COL, ST_WE, ST_DONE, ST_PRE, ST_RF_CAS, ST_RF_RAS, ST_RF_END} edoc_state_e;
  edoc_state_e st_r;
  logic [3:0] cnt_r;
  logic [1:0] cmd_r;
  logic [15:0] addr_r;
  logic [1:0] be_r;
  logic [15:0] wdata_r;
  logic tick;
  logic rf_pend_r;
  logic step;
  assign step = (cnt_r == 4'(PULSE - 1));

  edoc_tick #(.INTERVAL(REFRESH_INTERVAL)) u_tick (.clk(clk), .srst(srst), .tick(tick));

  // request wins only when no refresh is owed, so refresh never slips past its interval
  always_ff @(posedge clk) begin
    if (srst) begin
      rf_pend_r <= 1'b0;
    end else if (tick) begin
      rf_pend_r <= 1'b1;
    end else if (st_r == ST_RF_CAS) begin
      rf_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      cmd_r <= edoc_pkg::CMD_READ;
      addr_r <= 16'h0000;
      be_r <= 2'h0;
      wdata_r <= 16'h0000;
    end else begin
      cnt_r <= step ? 4'h0 : cnt_r + 4'h1;
      case (st_r)
        ST_IDLE: begin
          cnt_r <= 4'h0;
          if (rf_pend_r) begin
            st_r <= ST_RF_CAS;
          end else if (req) begin
            cmd_r <= req_cmd;
            addr_r <= req_addr;
            be_r <= req_be;
            wdata_r <= req_wdata;
            st_r <= ST_ROW;
          end
        end
        ST_ROW: if (step) st_r <= ST_COL;
        ST_COL: if (step) st_r <= (cmd_r == edoc_pkg::CMD_LATE_WRITE || cmd_r == edoc_pkg::CMD_RMW) ? ST_WE : ST_DONE;
        ST_WE: if (step) st_r <= ST_DONE;
        ST_DONE: st_r <= ST_PRE;
        ST_PRE: if (step) st_r <= ST_IDLE;
        ST_RF_CAS: if (step) st_r <= ST_RF_RAS;
        ST_RF_RAS: if (step) st_r <= ST_RF_END;
        ST_RF_END: if (step) st_r <= ST_PRE;
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      strobes <= '1;
      addr_out <= 8'h00;
      dq_out <= 16'h0000;
      dq_oe <= 1'b0;
      ack <= 1'b0;
      rdata <= 16'h0000;
      busy <= 1'b0;
    end else begin
      ack <= 1'b0;
      busy <= (st_r != ST_IDLE);
      case (st_r)
        ST_IDLE: begin
          strobes <= '1;
          dq_oe <= 1'b0;
          if (!rf_pend_r && req) begin
            addr_out <= req_addr[15:8];
            strobes.row_strobe_n <= 1'b0;
            // early write: write strobe low before column strobe falls
            strobes.write_strobe_n <= (req_cmd != edoc_pkg::CMD_EARLY_WRITE);
            strobes.output_gate_n <= (req_cmd == edoc_pkg::CMD_EARLY_WRITE);
            if (req_cmd == edoc_pkg::CMD_EARLY_WRITE) begin
              dq_out <= req_wdata;
              dq_oe <= 1'b1;
            end
          end
        end
        ST_ROW: if (step) begin
          addr_out <= addr_r[7:0];
          // each byte lane's strobe gets the full pulse width on its own
          strobes.lower_byte_strobe_n <= ~be_r[0];
          strobes.upper_byte_strobe_n <= ~be_r[1];
        end
        ST_COL: if (step) begin
          if (!strobes.output_gate_n) rdata <= dq_in;
          if (cmd_r == edoc_pkg::CMD_LATE_WRITE || cmd_r == edoc_pkg::CMD_RMW) begin
            strobes.output_gate_n <= 1'b1;
            dq_out <= wdata_r;
          end
        end
        ST_WE: begin
          // gate already high one cycle, so the device has released the pins
          dq_oe <= 1'b1;
          if (step) strobes.write_strobe_n <= 1'b0;
        end
        ST_DONE: begin
          // gate stays high so written data is not driven back
          strobes <= '1;
          ack <= 1'b1;
        end
        ST_PRE: begin
          strobes <= '1;
          dq_oe <= 1'b0;
        end
        ST_RF_CAS: begin
          // row strobe waits for the next state so the byte strobes get a full setup pulse
          strobes.lower_byte_strobe_n <= 1'b0;
          strobes.upper_byte_strobe_n <= 1'b0;
        end
        ST_RF_RAS: strobes.row_strobe_n <= 1'b0;
        ST_RF_END: begin
          strobes.lower_byte_strobe_n <= 1'b1;
          strobes.upper_byte_strobe_n <= 1'b1;
          if (step) strobes.row_strobe_n <= 1'b1;
        end
        default: strobes <= '1;
      endcase
    end
  end

  a_refresh_order: assert property (@(posedge clk) disable iff (srst)
    $fell(strobes.row_strobe_n) && $past(st_r) == ST_RF_RAS |->
    !$past(strobes.lower_byte_strobe_n) && !$past(strobes.upper_byte_strobe_n))
    else $error("refresh row strobe fell without column strobes low");
  a_gate_high_write: assert property (@(posedge clk) disable iff (srst)
    $fell(strobes.write_strobe_n) && !strobes.row_strobe_n && st_r != ST_IDLE |-> strobes.output_gate_n)
    else $error("write strobe fell with output gate low");
  a_drive_gate_high: assert property (@(posedge clk) disable iff (srst)
    dq_oe |-> strobes.output_gate_n)
    else $error("data driven while output gate low");
  a_ack_pulse: assert property (@(posedge clk) disable iff (srst)
    ack |=> !ack && strobes.row_strobe_n && strobes.lower_byte_strobe_n)
    else $error("strobes not high after ack");
  a_early_data: assert property (@(posedge clk) disable iff (srst)
    $fell(strobes.lower_byte_strobe_n) && !strobes.write_strobe_n && st_r == ST_COL |-> dq_oe)
    else $error("early write data missing at column strobe");
  a_refresh_owed: assert property (@(posedge clk) disable iff (srst)
    tick |-> ##[1:40] st_r == ST_RF_CAS)
    else $error("refresh not started in time");
  a_col_pulse: assert property (@(posedge clk) disable iff (srst)
    $fell(strobes.lower_byte_strobe_n) |=> !strobes.lower_byte_strobe_n)
    else $error("lower byte strobe pulse too short");
  a_row_before_col: assert property (@(posedge clk) disable iff (srst)
    $fell(strobes.lower_byte_strobe_n) && st_r == ST_COL |-> !strobes.row_strobe_n)
    else $error("column strobe fell before row strobe in access");
endmodule

// ===== hw/edoc_pkg.sv
// package for the page-mode dram controller: timing counts, commands, pin carrier
// assumes a 20 MHz clock driving all logic
package edoc_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int REFRESH_ROWS = 256;
  localparam int REFRESH_PERIOD_MS = 4;
  // ms period split over all rows, rounded down so the deadline is never missed
  localparam int REFRESH_INTERVAL_CYC = (REFRESH_PERIOD_MS * 1000000) / (REFRESH_ROWS * CLK_PERIOD_NS);
  localparam int MIN_PULSE_NS = 25;
  localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] CMD_READ = 2'h0;
  localparam logic [1:0] CMD_EARLY_WRITE = 2'h1;
  localparam logic [1:0] CMD_LATE_WRITE = 2'h2;
  localparam logic [1:0] CMD_RMW = 2'h3;
  typedef struct packed {
    logic row_strobe_n;
    logic lower_byte_strobe_n;
    logic upper_byte_strobe_n;
    logic write_strobe_n;
    logic output_gate_n;
  } edoc_strobes_s;
endpackage

// ===== hw/edoc_tick.sv
// refresh interval timer: one-cycle tick every interval
// assumes synchronous active-high reset
`timescale 1ns/100ps
module edoc_tick #(
  parameter int INTERVAL = edoc_pkg::REFRESH_INTERVAL_CYC
) (
  input wire logic clk,
  input wire logic srst,
  output logic tick
);
  logic [15:0] cnt_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt_r == 16'(INTERVAL - 1)) begin
      cnt_r <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule

// ===== test/edoc_dram_model.sv
// behavioural 64K x 16 page-mode dram on the controller pins
// assumes registered strobes; handlers wait 1 ns so same-edge updates settle
`timescale 1ns/100ps
module edoc_dram_model (
  input wire edoc_pkg::edoc_strobes_s s,
  input wire logic [7:0] addr_out,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe,
  output logic [15:0] dq_in,
  output int refresh_cnt,
  output int gate_err
);
  logic [15:0] mem [0:65535];
  logic [7:0] row = 8'h00;
  logic [7:0] col = 8'h00;
  logic column_first_refresh = 1'b0;
  logic lo_on, hi_on;
  // undriven bus reads as a fixed pattern, never as last data
  wire [15:0] wd = dq_oe ? dq_out : 16'hA5A5;
  wire [15:0] rd = mem[{row, col}];
  wire cas_lo = !(s.lower_byte_strobe_n && s.upper_byte_strobe_n);
  initial begin
    refresh_cnt = 0;
    gate_err = 0;
    for (int i = 0; i < 65536; i++) mem[i] = 16'h0000;
  end
  task automatic wr(input logic [1:0] be);
    if (be[0]) mem[{row, col}][7:0] = wd[7:0];
    if (be[1]) mem[{row, col}][15:8] = wd[15:8];
  endtask
  always @(negedge s.row_strobe_n) begin
    #1;
    column_first_refresh = cas_lo;
    if (column_first_refresh) refresh_cnt++;
    else row = addr_out;
  end
  always @(negedge s.lower_byte_strobe_n) begin
    #1;
    col = addr_out;
    if (!column_first_refresh && !s.row_strobe_n && !s.write_strobe_n) wr(2'b01);
  end
  always @(negedge s.upper_byte_strobe_n) begin
    #1;
    col = addr_out;
    if (!column_first_refresh && !s.row_strobe_n && !s.write_strobe_n) wr(2'b10);
  end
  always @(negedge s.write_strobe_n) begin
    #1;
    if (!column_first_refresh && !s.row_strobe_n && cas_lo) begin
      if (!s.output_gate_n) gate_err++;
      wr({!s.upper_byte_strobe_n, !s.lower_byte_strobe_n});
    end
  end
  assign lo_on = !s.lower_byte_strobe_n && !s.output_gate_n && s.write_strobe_n && !column_first_refresh;
  assign hi_on = !s.upper_byte_strobe_n && !s.output_gate_n && s.write_strobe_n && !column_first_refresh;
  assign dq_in = {hi_on ? rd[15:8] : ~rd[15:8], lo_on ? rd[7:0] : ~rd[7:0]};
endmodule

// ===== test/tb_edoc_ctrl.sv
// self-checking bench for the dram controller
// assumes the behavioural dram sits directly on the pins
`timescale 1ns/100ps
module tb_edoc_ctrl;
  localparam int RI = 50;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic req = 1'b0;
  logic [1:0] req_cmd = 2'h0;
  logic [15:0] req_addr = 16'h0000;
  logic [1:0] req_be = 2'h3;
  logic [15:0] req_wdata = 16'h0000;
  logic ack, busy, dq_oe;
  logic [15:0] rdata, dq_out, dq_in, r;
  logic [7:0] addr_out;
  edoc_pkg::edoc_strobes_s strobes;
  int refresh_cnt, gate_err, base;
  int error_cnt = 0;
  int n_compared = 0;
  always #25 clk = ~clk;
  edoc_ctrl #(.REFRESH_INTERVAL(RI), .PULSE(1)) i_dut (.clk(clk), .srst(srst), .req(req), .req_cmd(req_cmd),
    .req_addr(req_addr), .req_be(req_be), .req_wdata(req_wdata), .ack(ack), .rdata(rdata), .busy(busy),
    .strobes(strobes), .addr_out(addr_out), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
  edoc_dram_model i_mem (.s(strobes), .addr_out(addr_out), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
    .refresh_cnt(refresh_cnt), .gate_err(gate_err));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic acc(input logic [1:0] c, input logic [15:0] a, input logic [1:0] b, input logic [15:0] w);
    int n;
    n = 0;
    req = 1'b1;
    req_cmd = c;
    req_addr = a;
    req_be = b;
    req_wdata = w;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (ack !== 1'b1 && n < 200);
    check("ack", {31'h0, ack}, 32'h1);
    check("busy", {31'h0, busy}, 32'h1);
    r = rdata;
    req = 1'b0;
    @(posedge clk);
    #1;
  endtask
  // every write kind, with a second address one row up and one column down
  task automatic t_write_kinds();
    for (int c = 1; c < 4; c++) begin
      acc(2'h1, 16'h0102 + c, 2'h3, 16'h1111 * c);
      acc(2'h1, 16'h0201 + c, 2'h3, 16'hF0F0);
      acc(c[1:0], 16'h0102 + c, 2'h3, 16'h0C3C + c);
      if (c == 3) check("rmw old", r, 16'h3333);
      acc(2'h0, 16'h0102 + c, 2'h3, 16'h0000);
      check("read back", r, 16'h0C3C + c);
      acc(2'h0, 16'h0201 + c, 2'h3, 16'h0000);
      check("other row", r, 16'hF0F0);
    end
  endtask
  task automatic t_lanes();
    acc(2'h1, 16'h4455, 2'h3, 16'h1234);
    acc(2'h2, 16'h4455, 2'h1, 16'hABCD);
    acc(2'h1, 16'h4455, 2'h2, 16'h5600);
    acc(2'h0, 16'h4455, 2'h3, 16'h0000);
    check("lanes", r, 16'h56CD);
  endtask
  task automatic t_refresh();
    base = refresh_cnt;
    repeat (4 * RI + 20) @(posedge clk);
    #1;
    check("refresh count", refresh_cnt - base >= 4, 32'h1);
    check("gate high in write", gate_err, 32'h0);
    check("idle oe", {31'h0, dq_oe}, 32'h0);
  endtask
  initial begin
    #(50 * 20000);
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge clk);
    #1;
    check("reset strobes", strobes, 32'h1F);
    check("reset busy", {31'h0, busy}, 32'h0);
    srst = 1'b0;
    t_write_kinds();
    t_lanes();
    t_refresh();
    test_done();
  end
endmodule
